// ==== shutdown_defs.svh ====
// Register map, field positions, reset values and level codes of the shutdown block.
// Assumes byte addresses on a 32-bit APB bus, one aligned word per register.
// Notes on behaviour
// - Restart enable set means shutdown ends by itself once no source fires; clear means not.
// - In shutdown the first output pair is forced to one, zero, tri-state or inactive level.
// - Level code 00 puts the polarity-adjusted inactive level on once the dead band has run.
// - With the shutdown bit cleared, outputs stay shut until the next data input rising edge.
// - The comparator two enable lets that comparator trigger shutdown; cleared, it is ignored.
// - The comparator one enable lets that comparator trigger shutdown; cleared, it is ignored.
`ifndef SHUTDOWN_DEFS_SVH
`define SHUTDOWN_DEFS_SVH

`define OFS_STATE_CTL 12'h000
`define OFS_SRC_EN 12'h004
`define OFS_DEAD_BAND 12'h008
`define OFS_POLARITY 12'h00C
`define OFS_IRQ_STATUS 12'h010
`define OFS_IRQ_MASK 12'h014

`define BIT_SHUTDOWN 7
`define BIT_RESTART_EN 6
`define POS_SECOND_LEVEL 4
`define POS_FIRST_LEVEL 2
`define BIT_SRC_PIN 0
`define BIT_SRC_CMP1 1
`define BIT_SRC_CMP2 2
`define BIT_SRC_THIRD 3
`define BIT_SRC_LOGIC 4
`define BIT_IRQ_ENTER 0
`define BIT_IRQ_RESUME 1

`define RST_STATE_CTL 8'h00
`define RST_SRC_EN 5'h00
`define RST_DEAD_BAND 6'h00
`define RST_POLARITY 4'h0
`define RST_IRQ 2'h0

`define LVL_ONE 2'b11
`define LVL_ZERO 2'b10
`define LVL_TRISTATE 2'b01
`define LVL_INACTIVE 2'b00

`endif

// ==== shutdown_pkg.sv ====
// Types shared by the shutdown block and its per-pin output stage.
// Assumes the constants of shutdown_defs.svh.
package shutdown_pkg;

  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_DEAD = 2'b01,
    MODE_HELD = 2'b10,
    MODE_WAIT = 2'b11
  } shut_mode_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic pin;
    logic cmp1;
    logic cmp2;
    logic third;
    logic logic_cell;
  } shut_src_t;

endpackage

// ==== shutdown_pin_stage.sv ====
// Output value and enable of one generator pin, normal or shut down.
// Assumes level codes from shutdown_defs.svh; purely combinational.
`timescale 1ns/1ps
`include "shutdown_defs.svh"
module shutdown_pin_stage
  import shutdown_pkg::*;
(
  input wire logic [1:0] level_i,
  input wire logic polarity_i,
  input wire logic normal_i,
  input wire logic shut_i,
  input wire logic dead_done_i,
  output logic value_o,
  output logic drive_o
);

  always_comb
  begin
    value_o = normal_i ^ polarity_i;
    drive_o = 1'b1;
    if (shut_i)
    begin
      case (level_i)
        `LVL_ONE: value_o = 1'b1;
        `LVL_ZERO: value_o = 1'b0;
        `LVL_TRISTATE:
        begin
          value_o = 1'b0;
          drive_o = 1'b0;
        end
        default:
        begin
          // Until the dead band has run the pin keeps driving its polarity-adjusted normal level
          if (dead_done_i)
          begin
            value_o = polarity_i;
          end
        end
      endcase
    end
  end

endmodule

// ==== shutdown_control.sv ====
// Auto-shutdown control of a four-output complementary waveform unit, APB register slave.
// Assumes the steering logic delivers the raw A..D levels and all inputs share ref_clk_i.
`timescale 1ns/1ps
`include "shutdown_defs.svh"
module shutdown_control
  import shutdown_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire apb_req_t apb_i,
  output apb_rsp_t apb_o,
  input wire shut_src_t src_i,
  input wire logic data_in_i,
  input wire logic [3:0] normal_i,
  output logic [3:0] out_o,
  output logic [3:0] out_en_o,
  output logic shutdown_o,
  output logic irq_o
);

  typedef struct packed {
    logic [7:0] state_ctl;
    logic [4:0] src_en;
    logic [5:0] dead_band;
    logic [3:0] polarity;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    shut_mode_t mode;
    logic [5:0] dead_left;
    logic data_prev;
    logic [3:0] out;
    logic [3:0] out_en;
    logic irq;
    logic shut;
    apb_rsp_t rsp;
  } state_t;

  state_t r;
  state_t next_r;

  logic [4:0] src_vec;
  logic event_hit;
  logic shut_now;
  logic dead_done;
  logic [3:0] pin_value;
  logic [3:0] pin_drive;
  logic acc;
  logic wr;
  logic mapped;
  logic [31:0] rd_word;
  logic [1:0] first_level;
  logic [1:0] second_level;
  logic data_rise;

  assign src_vec = {src_i.logic_cell, src_i.third, src_i.cmp2, src_i.cmp1, src_i.pin};
  // Comparator enables gate their sources like all the others
  assign event_hit = |(src_vec & r.src_en);
  assign shut_now = (r.mode != MODE_RUN);
  // Held and waiting both lie past the dead band, so code 00 shows the inactive level there
  assign dead_done = (r.mode == MODE_HELD) || (r.mode == MODE_WAIT);
  // Rising edge of the data input against its value one clock earlier
  assign data_rise = data_in_i && !r.data_prev;

  // Each pair reads its own level field
  assign first_level = r.state_ctl[`POS_FIRST_LEVEL +: 2];
  assign second_level = r.state_ctl[`POS_SECOND_LEVEL +: 2];

  // Answer lands one cycle into the access phase, so every response bit is a flop
  assign acc = apb_i.psel && apb_i.penable && !r.rsp.pready;
  // Registers change only at the edge that completes the transfer, with pready seen high
  assign wr = apb_i.psel && apb_i.penable && apb_i.pwrite && r.rsp.pready;

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_pin
      // Pins 0 and 2 form the first pair, 1 and 3 the second
      shutdown_pin_stage u_pin (
        .level_i((g % 2 == 0) ? first_level : second_level),
        .polarity_i(r.polarity[g]),
        .normal_i(normal_i[g]),
        .shut_i(shut_now),
        .dead_done_i(dead_done),
        .value_o(pin_value[g]),
        .drive_o(pin_drive[g])
      );
    end
  endgenerate

  always_comb
  begin
    mapped = 1'b1;
    rd_word = 32'h0000_0000;
    // Unused upper bits read as zero
    case (apb_i.paddr)
      `OFS_STATE_CTL: rd_word = {24'h00_0000, r.state_ctl};
      `OFS_SRC_EN: rd_word = {27'h00_0000, r.src_en};
      `OFS_DEAD_BAND: rd_word = {26'h00_0000, r.dead_band};
      `OFS_POLARITY: rd_word = {28'h000_0000, r.polarity};
      `OFS_IRQ_STATUS: rd_word = {30'h000_0000, r.irq_status};
      `OFS_IRQ_MASK: rd_word = {30'h000_0000, r.irq_mask};
      default: mapped = 1'b0;
    endcase
  end

  always_comb
  begin
    next_r = r;
    next_r.data_prev = data_in_i;

    next_r.rsp.pready = acc;
    // An unmapped offset answers with an error and changes nothing
    next_r.rsp.pslverr = acc && !mapped;
    next_r.rsp.prdata = (acc && !apb_i.pwrite && mapped) ? rd_word : 32'h0000_0000;

    if (wr)
    begin
      case (apb_i.paddr)
        `OFS_STATE_CTL: next_r.state_ctl = {apb_i.pwdata[7:2], 2'b00};
        `OFS_SRC_EN: next_r.src_en = apb_i.pwdata[4:0];
        `OFS_DEAD_BAND: next_r.dead_band = apb_i.pwdata[5:0];
        `OFS_POLARITY: next_r.polarity = apb_i.pwdata[3:0];
        `OFS_IRQ_STATUS: next_r.irq_status = r.irq_status & ~apb_i.pwdata[1:0];
        `OFS_IRQ_MASK: next_r.irq_mask = apb_i.pwdata[1:0];
        default: ;
      endcase
    end

    // Auto-restart drops the shutdown bit once no enabled source is firing
    if (r.state_ctl[`BIT_RESTART_EN] && !event_hit && shut_now)
    begin
      next_r.state_ctl[`BIT_SHUTDOWN] = 1'b0;
    end
    // A firing source beats a clear in the same cycle
    if (event_hit)
    begin
      next_r.state_ctl[`BIT_SHUTDOWN] = 1'b1;
    end

    case (r.mode)
      // A set shutdown bit or an enabled source ends normal output
      MODE_RUN:
      begin
        if (r.state_ctl[`BIT_SHUTDOWN] || event_hit)
        begin
          next_r.mode = MODE_DEAD;
          next_r.dead_left = r.dead_band;
          next_r.irq_status[`BIT_IRQ_ENTER] = 1'b1;
        end
      end
      // A dead band of n keeps the old level on level code 00 pins for n+1 cycles
      MODE_DEAD:
      begin
        if (r.dead_left == 6'h00)
        begin
          next_r.mode = MODE_HELD;
        end
        else
        begin
          next_r.dead_left = r.dead_left - 6'h01;
        end
      end
      // Leaves only once the bit drops, by software or by restart
      MODE_HELD:
      begin
        if (!r.state_ctl[`BIT_SHUTDOWN])
        begin
          next_r.mode = MODE_WAIT;
        end
      end
      // A new event here skips a second dead band, the pins are already parked
      MODE_WAIT:
      begin
        if (r.state_ctl[`BIT_SHUTDOWN] || event_hit)
        begin
          next_r.mode = MODE_HELD;
        end
        else if (data_rise)
        begin
          next_r.mode = MODE_RUN;
          next_r.irq_status[`BIT_IRQ_RESUME] = 1'b1;
        end
      end
      default: next_r.mode = MODE_RUN;
    endcase

    next_r.out = pin_value;
    next_r.out_en = pin_drive;
    // Built from the next status so a new event and its interrupt appear together
    next_r.irq = |(next_r.irq_status & next_r.irq_mask);
    // Registered so that the flag leaves the block straight from a flop
    next_r.shut = (next_r.mode != MODE_RUN);
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      r <= '0;
      r.state_ctl <= `RST_STATE_CTL;
      r.src_en <= `RST_SRC_EN;
      r.dead_band <= `RST_DEAD_BAND;
      r.polarity <= `RST_POLARITY;
      r.irq_status <= `RST_IRQ;
      r.irq_mask <= `RST_IRQ;
      r.mode <= MODE_RUN;
      // Pins are driven from reset; only the tri-state code lets them go
      r.out_en <= 4'hF;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign apb_o = r.rsp;
  assign out_o = r.out;
  assign out_en_o = r.out_en;
  assign shutdown_o = r.shut;
  assign irq_o = r.irq;

endmodule

// ==== gate_driver_model.sv ====
// Power stage model driven by the four output pins.
// Assumes pins change only after clk_i edges.
`timescale 1ns/1ps
module gate_driver_model
(
  input wire logic clk_i,
  input wire logic [3:0] drive_i,
  input wire logic [3:0] drive_en_i,
  output logic [3:0] pin_o
);
  logic [3:0] last = 4'h0;
  // A floating pin toggles, so a stale level never passes for a driven one
  always @(posedge clk_i)
    last <= pin_o;
  assign pin_o = (drive_en_i & drive_i) | (~drive_en_i & ~last);
endmodule

// ==== shutdown_control_assertions.sv ====
// Checker for shutdown_control, bound to its ports.
// Assumes register shadows can be rebuilt from APB writes.
`timescale 1ns/1ps
module shutdown_control_chk
  import shutdown_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire apb_req_t apb_i,
  input wire apb_rsp_t apb_o,
  input wire shut_src_t src_i,
  input wire logic data_in_i,
  input wire logic [3:0] out_o,
  input wire logic [3:0] out_en_o,
  input wire logic shutdown_o
);
  logic [7:0] ctl;
  logic [4:0] en;
  logic [3:0] pol;
  logic [6:0] cnt;
  logic wr;
  logic hit;
  // Shadows update on the completing edge, as the design does, to avoid a lag
  assign wr = apb_i.psel & apb_i.penable & apb_i.pwrite & apb_o.pready;
  assign hit = |(en & {src_i.logic_cell, src_i.third, src_i.cmp2, src_i.cmp1, src_i.pin});
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
      {ctl, en, pol, cnt} <= '0;
    else
    begin
      if (wr && apb_i.paddr == 12'h000)
        ctl <= apb_i.pwdata[7:0];
      if (wr && apb_i.paddr == 12'h004)
        en <= apb_i.pwdata[4:0];
      if (wr && apb_i.paddr == 12'h00C)
        pol <= apb_i.pwdata[3:0];
      cnt <= shutdown_o ? cnt + {6'h00, cnt != 7'h7F} : 7'h00;
    end
  end
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  sequence quiet_rise;
    (!hit && !data_in_i) [*3] ##1 (!hit && data_in_i);
  endsequence
  AST_AUTO_RESTART: assert property (ctl[6] && shutdown_o ##1 quiet_rise
    |-> ##[1:2] !shutdown_o) else $error("no restart");
  AST_FIRST_PAIR: assert property (shutdown_o && $past(shutdown_o) && $past(ctl[3:2]) != 0
    |-> out_en_o[0] == ($past(ctl[3:2]) != 2'b01) && out_en_o[2] == out_en_o[0]
    && (!out_en_o[0] || out_o[0] == $past(ctl[2]) && out_o[2] == $past(ctl[2])))
    else $error("pair ac");
  AST_SECOND_PAIR: assert property (shutdown_o && $past(shutdown_o) && $past(ctl[5:4]) != 0
    |-> out_en_o[1] == ($past(ctl[5:4]) != 2'b01) && out_en_o[3] == out_en_o[1]
    && (!out_en_o[1] || out_o[1] == $past(ctl[4]) && out_o[3] == $past(ctl[4])))
    else $error("pair bd");
  // Past the longest dead band the inactive level must stand
  AST_INACTIVE: assert property (cnt == 7'h42 && ctl[3:2] == 2'b00
    |-> out_en_o[0] && out_en_o[2] && out_o[0] == pol[0] && out_o[2] == pol[2])
    else $error("inactive");
  AST_CMP_TWO: assert property (src_i.cmp2 && en[2] |=> shutdown_o)
    else $error("cmp2");
  AST_CMP_ONE: assert property (src_i.cmp1 && en[1] |=> shutdown_o)
    else $error("cmp1");
  AST_RESUME: assert property ($fell(shutdown_o) |-> $past(data_in_i) && !$past(data_in_i, 2))
    else $error("resume");
endmodule
bind shutdown_control shutdown_control_chk u_chk (.ref_clk_i, .reset_n_i, .apb_i, .apb_o,
  .src_i, .data_in_i, .out_o, .out_en_o, .shutdown_o);

// ==== testbench.sv ====
// Bench: APB register access and shutdown sequences.
// Assumes the power stage model on the pins.
`timescale 1ns/1ps
module testbench import shutdown_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic din = 1'b0;
  logic shut, irq, rerr;
  logic [3:0] out, oen, pins;
  logic [31:0] rdat;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  shut_src_t src = '0;
  int err_total = 0;
  int tests_run = 0;
  always #20 clk = ~clk;
  shutdown_control u_shutdown_control (.ref_clk_i(clk), .reset_n_i(rst_n), .apb_i(req),
    .apb_o(rsp), .src_i(src), .data_in_i(din), .normal_i(4'hF), .out_o(out),
    .out_en_o(oen), .shutdown_o(shut), .irq_o(irq));
  gate_driver_model u_gate_driver_model (.clk_i(clk), .drive_i(out), .drive_en_i(oen),
    .pin_o(pins));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    while (rsp.pready !== 1'b1)
      @(posedge clk);
    rdat = rsp.prdata;
    rerr = rsp.pslverr;
    req <= '0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 24; i += 4)
      rd(12'(i), 32'h0);
    rd(12'h018, 32'h0);
    chk(rerr, 1'b1);
    apb(1'b1, 12'h004, 32'h6);
    apb(1'b1, 12'h00C, 32'h5);
    apb(1'b1, 12'h000, 32'h2C);
    src.cmp1 <= 1'b1;
    repeat (4) @(posedge clk);
    chk({shut, oen, pins}, 9'h1F5);
    src.cmp1 <= 1'b0;
    rd(12'h000, 32'hAC);
    rd(12'h010, 32'h1);
    chk(irq, 1'b0);
    apb(1'b1, 12'h014, 32'h1);
    @(posedge clk);
    chk(irq, 1'b1);
    apb(1'b1, 12'h010, 32'h1);
    @(posedge clk);
    chk(irq, 1'b0);
    apb(1'b1, 12'h000, 32'h2C);
    repeat (4) @(posedge clk);
    chk({shut, pins}, 5'h15);
    din <= 1'b1;
    repeat (3) @(posedge clk);
    chk({shut, oen, pins}, 9'h0FA);
    apb(1'b1, 12'h008, 32'h3);
    for (int l = 0; l < 4; l++)
    begin
      apb(1'b1, 12'h000, 32'(8'h40 | l << 4 | l << 2));
      src.cmp2 <= 1'b1;
      repeat (70) @(posedge clk);
      chk({oen, pins & oen}, {l == 1 ? 4'h0 : 4'hF,
        l == 3 ? 4'hF : l == 0 ? 4'h5 : 4'h0});
      src.cmp2 <= 1'b0;
      din <= 1'b0;
      repeat (3) @(posedge clk);
      rd(12'h000, 32'(8'h40 | l << 4 | l << 2));
      chk(shut, 1'b1);
      din <= 1'b1;
      repeat (3) @(posedge clk);
      chk(shut, 1'b0);
    end
    rd(12'h010, 32'h3);
    chk(irq, 1'b1);
    apb(1'b1, 12'h004, 32'h19);
    src.cmp1 <= 1'b1;
    src.cmp2 <= 1'b1;
    repeat (4) @(posedge clk);
    chk(shut, 1'b0);
    report_and_stop();
  end
endmodule
